// *** hdl/gpm_pad_mode_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpm_consts.svh"
// Notes on behaviour
// [RULE1] strobe is write 0,1,0; pads settle two cpu clocks later
// [RULE2] while strobe is 1, pad mode latches pass register bits straight through
// [RULE3] software clears strobe so the pads capture the mode bits
// [RULE4] pull-up-off read returns the pad latch value
// [RULE5] pull-up-off latch set disables pull-ups on pins one and two
// [RULE6] button-matrix read returns the pad latch value
// [RULE7] matrix latch set drives pins one to three low, pull-ups off
// [RULE8] double-drive bit doubles drive strength of all output pads
// [RULE9] separate mid trip selects for led pin five and other inputs
// [RULE10] led level 00 off, 01 0.62, 10 1.00, 11 1.62 units
// [RULE11] led flows only with nonzero level and port0 bit five set
// [RULE12] external irq any-edge bit 1 both edges, else polarity edge
// [RULE13] clock pin select bit0 pin four, bit1 pin six
// [RULE14] both clock pins allowed; enable gates only the waveform
// [RULE15] clearing clock enable finishes current period then holds 0
// [RULE16] reference enable forces pin three to input, over port0 settings
// [RULE17] software writes 0 to two reserved low bits
// [RULE18] port0 bit five read returns 0 when led level is zero
// [RULE19] open-drain pin keeps pull-up unless pull-up-off; push-pull none; code also drops it on pins one to three while the matrix latch is set
// [RULE20] pad latches hold while strobe is 0 until next strobe
module gpm_pad_mode_ctrl
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // special-function bus
  input  wire gpm_pkg::gpm_sfr_s     sfr,
  output var  logic [7:0]            sfr_rdata,
  // port 0 settings and state
  input  wire logic [7:0]            port0_data,
  input  wire logic [7:0]            port0_config,
  input  wire logic [7:0]            gpio_in,
  output var  logic                  port0_bit5_read,
  // external interrupts
  input  wire logic [1:0]            ext_irq_line,
  input  wire logic [1:0]            ext_irq_polarity,
  output var  logic [1:0]            ext_irq_event,
  // clock divider handshake
  input  wire logic                  clk_div_wave,
  input  wire logic                  clk_div_period_end,
  output var  logic                  clk_div_run,
  // pad controls
  output var  logic [7:0]            pad_pullup_en,
  output var  logic [7:0]            pad_force_low,
  output var  logic [7:0]            pad_force_input,
  output var  logic [7:0]            pad_clk_sel,
  output var  logic                  pad_clk_wave,
  output var  gpm_pkg::gpm_pad_elec_s pad_elec,
  output var  logic                  led_drive,
  output var  logic                  strobe_done
);
  logic [7:0]          pad_control;
  logic [7:0]          pin_function_setup;
  logic                pullup_off_latch;
  logic                matrix_latch;
  logic [1:0]          settle_cnt;
  logic                clk_run;
  gpm_pkg::gpm_strobe_e st;
  gpm_pkg::gpm_strobe_e next_st;

  wire wr_pc = sfr.wr && (sfr.addr == `GPM_ADDR_PAD_CONTROL);
  wire wr_ps = sfr.wr && (sfr.addr == `GPM_ADDR_PIN_FUNC_SETUP);
  wire strobe = pad_control[`GPM_PC_STROBE];
  wire clken = pin_function_setup[`GPM_PS_CLKEN];
  wire [1:0] led_lvl = pad_control[`GPM_PC_LED_LVL_HI:`GPM_PC_LED_LVL_LO];

  // reads show latch state for the mode bits
  wire [7:0] pc_read = {strobe, pullup_off_latch, matrix_latch, pad_control[4:0]}; // [RULE4] [RULE6]
  wire [7:0] next_rdata = (sfr.addr == `GPM_ADDR_PAD_CONTROL) ? pc_read :
                          (sfr.addr == `GPM_ADDR_PIN_FUNC_SETUP) ? pin_function_setup : 8'h00;

  // pad mode latches transparent while strobe open, hold otherwise
  wire next_roff = strobe ? pad_control[`GPM_PC_PULLUP_OFF] : pullup_off_latch; // [RULE2] [RULE20]
  wire next_mtx  = strobe ? pad_control[`GPM_PC_MATRIX] : matrix_latch; // [RULE2] [RULE20]

  // strobe sequence tracker
  always_comb
  begin
    next_st = st;
    unique case (st)
      gpm_pkg::GPM_ST_IDLE:   if (strobe) next_st = gpm_pkg::GPM_ST_OPEN;
      gpm_pkg::GPM_ST_OPEN:   if (!strobe) next_st = gpm_pkg::GPM_ST_SETTLE; // [RULE3]
      gpm_pkg::GPM_ST_SETTLE: if (strobe) next_st = gpm_pkg::GPM_ST_OPEN;
                              else if (settle_cnt == `GPM_STROBE_SETTLE - 2'h1) next_st = gpm_pkg::GPM_ST_IDLE;
      default:                next_st = gpm_pkg::GPM_ST_IDLE;
    endcase
  end
  wire [1:0] next_settle = (st == gpm_pkg::GPM_ST_SETTLE) ? settle_cnt + 2'h1 : 2'h0;
  wire next_done = (st == gpm_pkg::GPM_ST_SETTLE) && !strobe &&
                   (settle_cnt == `GPM_STROBE_SETTLE - 2'h1); // [RULE1]

  // clock run: stops only at a period boundary
  wire next_clk_run = clken ? 1'b1 : (clk_run && !clk_div_period_end); // [RULE15]
  wire next_wave = clk_run & clk_div_wave; // [RULE14] [RULE15]
  wire [7:0] next_clk_sel = {1'b0, pin_function_setup[`GPM_PS_CLKPIN_HI], 1'b0,
                             pin_function_setup[`GPM_PS_CLKPIN_LO], 4'h0}; // [RULE13] [RULE14]

  // pull-ups: open-drain keeps it unless roff or matrix remove it
  logic [7:0] next_pullup;
  logic [7:0] next_low;
  logic [7:0] next_fin;
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      wire roff_hit = pullup_off_latch && (g == 1 || g == 2); // [RULE5]
      wire mtx_hit  = matrix_latch && (g >= 1 && g <= 3); // [RULE7]
      wire ref_hit  = pin_function_setup[`GPM_PS_REFEN] && (g == 3); // [RULE16]
      assign next_pullup[g] = !port0_config[g] && !roff_hit && !mtx_hit; // [RULE19]
      assign next_low[g]    = mtx_hit && !ref_hit;
      assign next_fin[g]    = ref_hit;
    end
  endgenerate

  // led decode
  logic [3:0] next_led_onehot;
  always_comb
  begin
    unique case (led_lvl)
      gpm_pkg::GPM_LED_OFF: next_led_onehot = 4'h1;
      gpm_pkg::GPM_LED_062: next_led_onehot = 4'h2;
      gpm_pkg::GPM_LED_100: next_led_onehot = 4'h4;
      gpm_pkg::GPM_LED_162: next_led_onehot = 4'h8;
    endcase
  end // [RULE10]
  gpm_pkg::gpm_pad_elec_s next_elec;
  assign next_elec = '{double_drive:     pad_control[`GPM_PC_DOUBLE_DRIVE], // [RULE8]
                       led_pin_mid_trip: pad_control[`GPM_PC_LED_MID_TRIP], // [RULE9]
                       input_mid_trip:   pad_control[`GPM_PC_INPUT_MID_TRIP],
                       led_current_onehot: next_led_onehot};
  wire next_led = port0_data[5] && (led_lvl != 2'h0); // [RULE11] [RULE18]

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pad_control        <= `GPM_PC_RESET;
      pin_function_setup <= `GPM_PS_RESET;
    end
    else
    begin
      if (wr_pc)
        pad_control <= sfr.wdata;
      if (wr_ps)
        pin_function_setup <= sfr.wdata & `GPM_PS_RSVD_MASK; // [RULE17]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pullup_off_latch <= 1'b0;
      matrix_latch     <= 1'b0;
      st               <= gpm_pkg::GPM_ST_IDLE;
      settle_cnt       <= 2'h0;
      strobe_done      <= 1'b0;
      clk_run          <= 1'b0;
    end
    else
    begin
      pullup_off_latch <= next_roff;
      matrix_latch     <= next_mtx;
      st               <= next_st;
      settle_cnt       <= next_settle;
      strobe_done      <= next_done;
      clk_run          <= next_clk_run;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rdata       <= 8'h00;
      port0_bit5_read <= 1'b0;
      clk_div_run     <= 1'b0;
      pad_pullup_en   <= 8'h00;
      pad_force_low   <= 8'h00;
      pad_force_input <= 8'h00;
      pad_clk_sel     <= 8'h00;
      pad_clk_wave    <= 1'b0;
      pad_elec        <= '0;
      led_drive       <= 1'b0;
    end
    else
    begin
      sfr_rdata       <= next_rdata;
      port0_bit5_read <= next_led;
      clk_div_run     <= next_clk_run;
      pad_pullup_en   <= next_pullup;
      pad_force_low   <= next_low;
      pad_force_input <= next_fin;
      pad_clk_sel     <= next_clk_sel;
      pad_clk_wave    <= next_wave;
      pad_elec        <= next_elec;
      led_drive       <= next_led;
    end
  end

  gpm_edge_det u_irq0
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .any_edge  (pin_function_setup[`GPM_PS_IRQ0_ANY]),
    .polarity  (ext_irq_polarity[0]),
    .line_in   (ext_irq_line[0]),
    .irq_event (ext_irq_event[0])
  );
  gpm_edge_det u_irq1
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .any_edge  (pin_function_setup[`GPM_PS_IRQ1_ANY]),
    .polarity  (ext_irq_polarity[1]),
    .line_in   (ext_irq_line[1]),
    .irq_event (ext_irq_event[1])
  );

  property p_latch_follow;
    @(posedge core_clk) disable iff (!reset_n)
      strobe |=> (pullup_off_latch == $past(pad_control[6]) && matrix_latch == $past(pad_control[5]));
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("latch not transparent"); // [RULE2]
  property p_latch_hold;
    @(posedge core_clk) disable iff (!reset_n)
      !strobe |=> $stable(pullup_off_latch) && $stable(matrix_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed while closed"); // [RULE20]
  // done pulses on the third edge after strobe closes, unless strobe reopened
  property p_settle;
    @(posedge core_clk) disable iff (!reset_n)
      (st == gpm_pkg::GPM_ST_OPEN && !strobe) |=>
        !strobe_done ##1 !strobe_done ##1 (strobe_done || $past(strobe) || $past(strobe, 2));
  endproperty
  a_settle: assert property (p_settle) else $error("strobe settle not two clocks"); // [RULE1]
  property p_roff_pull;
    @(posedge core_clk) disable iff (!reset_n)
      pullup_off_latch |=> (pad_pullup_en[2:1] == 2'h0);
  endproperty
  a_roff_pull: assert property (p_roff_pull) else $error("pull-up left on"); // [RULE5]
  property p_matrix_low;
    @(posedge core_clk) disable iff (!reset_n)
      (matrix_latch && !pin_function_setup[2]) |=> (pad_force_low[3:1] == 3'h7);
  endproperty
  a_matrix_low: assert property (p_matrix_low) else $error("matrix pins not low"); // [RULE7]
  property p_ref_force;
    @(posedge core_clk) disable iff (!reset_n)
      pin_function_setup[2] |=> pad_force_input[3] && !pad_force_low[3];
  endproperty
  a_ref_force: assert property (p_ref_force) else $error("ref pin not input"); // [RULE16]
  property p_led_zero;
    @(posedge core_clk) disable iff (!reset_n)
      (led_lvl == 2'h0) |=> !port0_bit5_read;
  endproperty
  a_led_zero: assert property (p_led_zero) else $error("led read with zero level"); // [RULE18]
  property p_clk_stop;
    @(posedge core_clk) disable iff (!reset_n)
      (!clken && !clk_run) |=> ##1 !pad_clk_wave;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clock wave while stopped"); // [RULE15]
  property p_clk_sel;
    @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> (pad_clk_sel[4] == $past(pin_function_setup[4]) && pad_clk_sel[6] == $past(pin_function_setup[5]));
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock pin select wrong"); // [RULE13]
  property p_pushpull;
    @(posedge core_clk) disable iff (!reset_n)
      port0_config[0] |=> !pad_pullup_en[0];
  endproperty
  a_pushpull: assert property (p_pushpull) else $error("push-pull pull-up on"); // [RULE19]
endmodule
`default_nettype wire

// *** include/gpm_consts.svh ***
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH
// sfr addresses
`define GPM_ADDR_PAD_CONTROL     8'hb5
`define GPM_ADDR_PIN_FUNC_SETUP  8'hb6
// pad_control fields
`define GPM_PC_STROBE            7
`define GPM_PC_PULLUP_OFF        6
`define GPM_PC_MATRIX            5
`define GPM_PC_DOUBLE_DRIVE      4
`define GPM_PC_LED_MID_TRIP      3
`define GPM_PC_INPUT_MID_TRIP    2
`define GPM_PC_LED_LVL_HI        1
`define GPM_PC_LED_LVL_LO        0
// pin_function_setup fields
`define GPM_PS_IRQ1_ANY          7
`define GPM_PS_IRQ0_ANY          6
`define GPM_PS_CLKPIN_HI         5
`define GPM_PS_CLKPIN_LO         4
`define GPM_PS_CLKEN             3
`define GPM_PS_REFEN             2
// reset values and reserved-bit write mask
`define GPM_PC_RESET             8'h0c
`define GPM_PS_RESET             8'h00
`define GPM_PS_RSVD_MASK         8'hfc
// strobe settle: cpu clocks after the 0->1->0 sequence
`define GPM_STROBE_SETTLE        2'h2
`endif

// *** include/gpm_pkg.sv ***
package gpm_pkg;
  typedef enum logic [1:0] {
    GPM_LED_OFF  = 2'h0,
    GPM_LED_062  = 2'h1,
    GPM_LED_100  = 2'h2,
    GPM_LED_162  = 2'h3
  } gpm_led_e;
  typedef enum logic [1:0] {
    GPM_ST_IDLE   = 2'h0,
    GPM_ST_OPEN   = 2'h1,
    GPM_ST_SETTLE = 2'h3
  } gpm_strobe_e;
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } gpm_sfr_s;
  typedef struct packed {
    logic       double_drive;
    logic       led_pin_mid_trip;
    logic       input_mid_trip;
    logic [3:0] led_current_onehot;
  } gpm_pad_elec_s;
endpackage

// *** hdl/gpm_edge_det.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gpm_consts.svh"
module gpm_edge_det
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // configuration
  input  wire logic any_edge,
  input  wire logic polarity,
  // line and event
  input  wire logic line_in,
  output var  logic irq_event
);
  logic sync1;
  logic sync2;
  logic prev;
  wire  rise = sync2 & ~prev;
  wire  fall = ~sync2 & prev;
  // polarity 1 selects falling edge
  wire  single = polarity ? fall : rise;
  wire  next_irq_event = any_edge ? (rise | fall) : single; // [RULE12]

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      prev      <= 1'b0;
      irq_event <= 1'b0;
    end
    else
    begin
      sync1     <= line_in;
      sync2     <= sync1;
      prev      <= sync2;
      irq_event <= next_irq_event;
    end
  end

  // event and prev move on the same edge, so the pulse is checked in that cycle
  property p_any_edge_pulse;
    @(posedge core_clk) disable iff (!reset_n)
      ($past(any_edge) && $changed(prev)) |-> irq_event;
  endproperty
  a_any_edge_pulse: assert property (p_any_edge_pulse) else $error("any-edge event missed"); // [RULE12]
endmodule
`default_nettype wire

// *** test/gpm_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpm_far_model
#(
  parameter int DIV = 4
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // divider side
  input  wire logic run,
  output var  logic wave,
  output var  logic period_end
);
  int cnt;
  // divider counts only while run is asked for, first half high, idle low
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      cnt <= 0;
    else if (!run)
      cnt <= 0;
    else
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
  always_comb
  begin
    wave = run && (cnt < DIV / 2);
    period_end = run && (cnt == DIV - 1);
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk, reset_n, run, wave, pend, cwave, b5r, led, sdone;
  gpm_pkg::gpm_sfr_s sfr;
  gpm_pkg::gpm_pad_elec_s elec;
  logic [7:0] rdata, p0d, p0c, pu, fl, fi, cs, v, d;
  logic [1:0] irq_l, irq_p, irq_e, lat;
  int err_total, samples_checked, pc, ps, i, e, m, cnt;
  gpm_pad_mode_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .sfr(sfr), .sfr_rdata(rdata),
    .port0_data(p0d), .port0_config(p0c), .gpio_in(8'h00), .port0_bit5_read(b5r),
    .ext_irq_line(irq_l), .ext_irq_polarity(irq_p), .ext_irq_event(irq_e),
    .clk_div_wave(wave), .clk_div_period_end(pend), .clk_div_run(run),
    .pad_pullup_en(pu), .pad_force_low(fl), .pad_force_input(fi), .pad_clk_sel(cs),
    .pad_clk_wave(cwave), .pad_elec(elec), .led_drive(led), .strobe_done(sdone));
  gpm_far_model far (.core_clk(core_clk), .reset_n(reset_n), .run(run), .wave(wave), .period_end(pend));
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] x);
    samples_checked++;
    if (s !== x)
    begin
      err_total++;
      $display("Error %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] x);
    @(posedge core_clk);
    sfr <= '{a, 1'b1, 1'b0, x};
    @(posedge core_clk);
    sfr.wr <= 1'b0;
    if (a == 8'hb6)
      ps = x & 8'hfc;
    else
      pc = x;
    if (a == 8'hb5 && x[7])
      lat = x[6:5];
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] r);
    @(posedge core_clk);
    sfr.addr <= a;
    sfr.rd <= 1'b1;
    tick(2);
    r = rdata;
    sfr.rd <= 1'b0;
  endtask
  task automatic regs();
    logic [7:0] r;
    rd(8'hb5, r);
    chk("pad_control", r, {pc[7], lat, pc[4:0]});
    rd(8'hb6, r);
    chk("pin_function_setup", r, ps[7:0]);
  endtask
  task automatic strobe(logic [1:0] b);
    wr(8'hb5, 8'h0c);
    wr(8'hb5, {1'b1, b, 5'h0c});
    tick(3);
    chk("pads_open", fl & 8'h0e, b[0] ? 8'h0e : 8'h00);
    wr(8'hb5, {1'b0, b, 5'h0c});
    for (cnt = 0; cnt < 12 && sdone !== 1'b1; cnt++)
      tick(1);
    chk("strobe_done", {7'h0, sdone}, 8'h01);
    tick(2);
    chk("force_low", fl & 8'h0e, b[0] ? 8'h0e : 8'h00);
    chk("pullup_off", pu & 8'h0e, (b == 2'b00) ? 8'h0e : (b[0] ? 8'h00 : 8'h08));
    regs();
  endtask
  initial
  begin
    tick(5000);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(92761));
    reset_n = 0;
    sfr = '0;
    {p0d, p0c, irq_l, irq_p} = '0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'hb5, v);
    chk("pad_control_rst", v & 8'h9f, 8'h0c);
    rd(8'hb6, v);
    chk("pin_function_setup_rst", v, 8'h00);
    strobe(2'b11);
    wr(8'hb5, 8'h0c);
    regs();
    strobe(2'b00);
    for (i = 0; i < 8; i++)
    begin
      d = {3'h0, 3'($urandom), 2'(i)};
      wr(8'hb5, d);
      p0c <= 8'($urandom);
      p0d <= 8'($urandom);
      tick(3);
      chk("pad_elec", {1'b0, elec}, {1'b0, d[4:2], 4'h1 << d[1:0]});
      chk("led_drive", {7'h0, led}, {7'h0, p0d[5] && d[1:0] != 0});
      chk("port0_bit5", {7'h0, b5r}, {7'h0, p0d[5] && d[1:0] != 0});
      chk("pullup", pu & 8'h1e, ~p0c & 8'h1e);
      d = {2'($urandom), 2'(i), 1'b0, 1'b1, 2'h0};
      wr(8'hb6, d);
      tick(3);
      chk("clk_sel", cs & 8'h50, {1'b0, d[5], 1'b0, d[4], 4'h0});
      chk("ref_input", {7'h0, fi[3]}, 8'h01);
      regs();
    end
    wr(8'hb6, 8'h18);
    tick(6);
    chk("clk_run", {7'h0, run}, 8'h01);
    wr(8'hb6, 8'h10);
    for (cnt = 0; cnt < 8 && run !== 1'b0; cnt++)
      tick(1);
    tick(2);
    chk("clk_stop", {6'h0, run, cwave}, 8'h00);
    for (m = 0; m < 3; m++)
    begin
      wr(8'hb6, m == 0 ? 8'hc0 : 8'h00);
      irq_p <= {2{m == 2}};
      for (e = 1; e >= 0; e--)
      begin
        tick(2);
        irq_l <= {2{e[0]}};
        v = 8'h00;
        repeat (8)
        begin
          tick(1);
          v = v + {3'h0, irq_e[1], 3'h0, irq_e[0]};
        end
        chk("irq_events", v, {2{3'h0, m == 0 || (e[0] ^ (m == 2))}});
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
